// >>> rtl/epiu_top.sv
// External pin interrupt unit: one dedicated pin with level or edge sensing
// and three pin-change groups over eighteen inputs, with flags, enables and
// vector requests. Assumes pins are synchronous to clk_sys and that the core
// supplies its global enable and pulses an acknowledge on vector entry.
`timescale 1ns/100ps

// Operation
// - Sense field selects low, change, fall, rise.
// - Dedicated request needs global and own enable.
// - Sample pin; longer pulses always produce requests.
// - Reserved bits always read as zero.
// - Group 2 enable gates inputs 17 to 12.
// - Group 1 enable gates inputs 11 to 8.
// - Group 0 enable gates inputs 7 to 0.
// - Dedicated enable bit 0; outputs still trigger.
// - Group flags set on unmasked pin change.
// - Flags clear on vector entry or write-one.
// - Set flag plus enables requests its vector.
// - Dedicated flag sets on edge, cleared in level.
// - Mask 2 bits enable inputs 17 to 12.
// - Mask 1 bits enable inputs 11 to 8.
// - Mask 0 bits enable inputs 7 to 0.
// - Pin-change detection can wake from sleep.
// - Low-level detection also wakes without edges.
module epiu_top (
    // Clock and reset.
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    // External pins.
    input  wire epiu_pkg::epiu_pins_s pins,
    // Register port.
    input  wire epiu_pkg::epiu_bus_s  bus,
    output logic [7:0]               rdata,
    // CPU core side.
    input  wire logic                cpu_global_en,
    input  wire logic [3:0]          vec_ack,
    output logic [3:0]               vec_req,
    // Event interrupt and wake.
    output logic                     irq,
    output logic                     wake_req
);

    // Register and next-state copy of the whole unit.
    epiu_pkg::epiu_state_s s_ff;
    epiu_pkg::epiu_state_s nxt_s;

    // Detection results, visible to the checks below.
    logic [17:0] pin_chg;    // Per-pin change between samples.
    logic        ded_evt;    // Qualifying edge on the dedicated pin.
    logic        g0_evt;     // Unmasked change in group 0.
    logic        g1_evt;     // Unmasked change in group 1.
    logic        g2_evt;     // Unmasked change in group 2.
    logic [7:0]  set_vec;    // Flag set pattern.
    logic [7:0]  clr_vec;    // Flag clear pattern.
    logic        level_low;  // Level mode with the pin low.

    // True when a strobe addresses the given offset.
    function automatic logic hit(input logic strobe, input logic [5:0] addr, input logic [5:0] off);
        hit = strobe && (addr == off);
    endfunction

    // Places one bit at a source position of the shared layout.
    function automatic logic [7:0] at_bit(input logic v, input int pos);
        at_bit = {7'h00, v} << pos;
    endfunction

    // Next-state logic for the whole unit.
    always_comb begin
        nxt_s = s_ff;
        // Pins pass through two stages; the first is read only by the second.
        nxt_s.sync1 = pins;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.prev  = s_ff.sync2;

        // Change detection compares the synchronised sample with the previous one.
        pin_chg = s_ff.sync2.change_input ^ s_ff.prev.change_input;
        g0_evt  = |(pin_chg[7:0] & s_ff.mask0);
        g1_evt  = |(pin_chg[11:8] & s_ff.mask1[3:0]);
        g2_evt  = |(pin_chg[17:12] & s_ff.mask2[5:0]);

        // Dedicated pin decode of the sense field.
        unique case (s_ff.sense)
            epiu_pkg::SENSE_LOW: begin
                // Level mode never sets the flag.
                ded_evt = 1'b0;
            end
            epiu_pkg::SENSE_ANY: begin
                // Any change on the pin.
                ded_evt = s_ff.sync2.dedicated_ext_irq ^ s_ff.prev.dedicated_ext_irq;
            end
            epiu_pkg::SENSE_FALL: begin
                // High to low only.
                ded_evt = !s_ff.sync2.dedicated_ext_irq && s_ff.prev.dedicated_ext_irq;
            end
            epiu_pkg::SENSE_RISE: begin
                // Low to high only.
                ded_evt = s_ff.sync2.dedicated_ext_irq && !s_ff.prev.dedicated_ext_irq;
            end
        endcase
        level_low = (s_ff.sense == epiu_pkg::SENSE_LOW) && !s_ff.sync2.dedicated_ext_irq;

        // Flags: hardware sets win over software or vector-entry clears.
        set_vec = at_bit(ded_evt, epiu_pkg::BIT_DED) | at_bit(g0_evt, epiu_pkg::BIT_G0)
                | at_bit(g1_evt, epiu_pkg::BIT_G1) | at_bit(g2_evt, epiu_pkg::BIT_G2);
        clr_vec = at_bit(vec_ack[epiu_pkg::VEC_DED], epiu_pkg::BIT_DED)
                | at_bit(vec_ack[epiu_pkg::VEC_G0], epiu_pkg::BIT_G0)
                | at_bit(vec_ack[epiu_pkg::VEC_G1], epiu_pkg::BIT_G1)
                | at_bit(vec_ack[epiu_pkg::VEC_G2], epiu_pkg::BIT_G2);
        if (hit(bus.wr, bus.addr, epiu_pkg::OFF_FLAGS)) begin
            // Writing one clears, writing zero leaves the flag alone.
            clr_vec = clr_vec | bus.wdata;
        end
        nxt_s.flags = ((s_ff.flags & ~clr_vec) | set_vec) & epiu_pkg::RW_SRC;
        if (s_ff.sense == epiu_pkg::SENSE_LOW) begin
            // Level sensing holds the dedicated flag cleared.
            nxt_s.flags[epiu_pkg::BIT_DED] = 1'b0;
        end

        // Register writes keep only the writable bits.
        if (hit(bus.wr, bus.addr, epiu_pkg::OFF_SENSE)) begin
            nxt_s.sense = epiu_pkg::epiu_sense_e'(bus.wdata[epiu_pkg::SENSE_LSB +: 2]);
        end
        if (hit(bus.wr, bus.addr, epiu_pkg::OFF_ENABLE)) begin
            nxt_s.enable = bus.wdata & epiu_pkg::RW_SRC;
        end
        if (hit(bus.wr, bus.addr, epiu_pkg::OFF_MASK0)) begin
            nxt_s.mask0 = bus.wdata & epiu_pkg::RW_MASK0;
        end
        if (hit(bus.wr, bus.addr, epiu_pkg::OFF_MASK1)) begin
            nxt_s.mask1 = bus.wdata & epiu_pkg::RW_MASK1;
        end
        if (hit(bus.wr, bus.addr, epiu_pkg::OFF_MASK2)) begin
            nxt_s.mask2 = bus.wdata & epiu_pkg::RW_MASK2;
        end
        if (hit(bus.wr, bus.addr, epiu_pkg::OFF_EVT_MASK)) begin
            nxt_s.evt_mask = bus.wdata & epiu_pkg::RW_SRC;
        end

        // Event status: a read clears it, but an event in that cycle survives.
        if (hit(bus.rd, bus.addr, epiu_pkg::OFF_EVT_STAT)) begin
            nxt_s.evt_stat = set_vec;
        end else begin
            nxt_s.evt_stat = s_ff.evt_stat | set_vec;
        end
        nxt_s.irq = |(nxt_s.evt_stat & nxt_s.evt_mask);

        // Read data stand for one cycle after the strobe; unmapped reads give zero.
        nxt_s.rdata = epiu_pkg::RST_REG;
        if (bus.rd) begin
            unique case (bus.addr)
                epiu_pkg::OFF_MASK0: begin
                    nxt_s.rdata = s_ff.mask0;
                end
                epiu_pkg::OFF_MASK1: begin
                    nxt_s.rdata = s_ff.mask1;
                end
                epiu_pkg::OFF_MASK2: begin
                    nxt_s.rdata = s_ff.mask2;
                end
                epiu_pkg::OFF_EVT_STAT: begin
                    nxt_s.rdata = s_ff.evt_stat;
                end
                epiu_pkg::OFF_EVT_MASK: begin
                    nxt_s.rdata = s_ff.evt_mask;
                end
                epiu_pkg::OFF_SENSE: begin
                    nxt_s.rdata = {s_ff.sense, 6'h00};
                end
                epiu_pkg::OFF_FLAGS: begin
                    nxt_s.rdata = s_ff.flags;
                end
                epiu_pkg::OFF_ENABLE: begin
                    nxt_s.rdata = s_ff.enable;
                end
                default: begin
                    nxt_s.rdata = epiu_pkg::RST_REG;
                end
            endcase
        end

        // Group vector requests need the global enable, the source enable and a flag.
        nxt_s.vec_req[epiu_pkg::VEC_G0] = cpu_global_en && nxt_s.enable[epiu_pkg::BIT_G0]
                                        && nxt_s.flags[epiu_pkg::BIT_G0];
        nxt_s.vec_req[epiu_pkg::VEC_G1] = cpu_global_en && nxt_s.enable[epiu_pkg::BIT_G1]
                                        && nxt_s.flags[epiu_pkg::BIT_G1];
        nxt_s.vec_req[epiu_pkg::VEC_G2] = cpu_global_en && nxt_s.enable[epiu_pkg::BIT_G2]
                                        && nxt_s.flags[epiu_pkg::BIT_G2];
        // The dedicated source requests on its flag, or for as long as the level is low.
        // Pins driven by this chip as outputs still arrive here, giving software interrupts.
        nxt_s.vec_req[epiu_pkg::VEC_DED] = cpu_global_en && nxt_s.enable[epiu_pkg::BIT_DED]
                                         && (nxt_s.flags[epiu_pkg::BIT_DED] || level_low);

        // Wake request ignores the global enable so that a sleeping core can be roused.
        nxt_s.wake = (level_low && s_ff.enable[epiu_pkg::BIT_DED])
                   || (g0_evt && s_ff.enable[epiu_pkg::BIT_G0])
                   || (g1_evt && s_ff.enable[epiu_pkg::BIT_G1])
                   || (g2_evt && s_ff.enable[epiu_pkg::BIT_G2]);
    end

    // State register; every field resets to zero.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs come straight from the state register.
    assign rdata    = s_ff.rdata;
    assign vec_req  = s_ff.vec_req;
    assign irq      = s_ff.irq;
    assign wake_req = s_ff.wake;

    // Checks run on the system clock and rest during reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Read data are zero unless a read strobe came one cycle before.
    read_idle_zero_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    // Group 1 mask reads back with its reserved bits at zero.
    mask1_reserved_a: assert property (hit(bus.rd, bus.addr, epiu_pkg::OFF_MASK1) |=> rdata[7:4] == 4'h0)
        else $error("reserved mask bits read as one");
    // Level mode keeps the dedicated flag down.
    level_flag_clear_a: assert property ((s_ff.sense == epiu_pkg::SENSE_LOW) && $past(s_ff.sense == epiu_pkg::SENSE_LOW) |-> !s_ff.flags[0])
        else $error("dedicated flag set in level mode");
    // A rising edge in rising mode sets the dedicated flag next cycle.
    rise_sets_flag_a: assert property ((s_ff.sense == epiu_pkg::SENSE_RISE) && s_ff.sync2.dedicated_ext_irq && !s_ff.prev.dedicated_ext_irq |=> s_ff.flags[0])
        else $error("rising edge lost");
    // A masked-in pin change three cycles back reaches the group 0 flag.
    pin_to_flag_a: assert property (($past(pins.change_input[0], 2) != $past(pins.change_input[0], 3)) && s_ff.mask0[0] |=> s_ff.flags[4])
        else $error("pin change did not set group flag");
    // Writing one clears a group 0 flag when no new change arrives.
    write_one_clear_a: assert property (hit(bus.wr, bus.addr, epiu_pkg::OFF_FLAGS) && bus.wdata[4] && !g0_evt |=> !s_ff.flags[4])
        else $error("write one did not clear flag");
    // Vector entry clears the dedicated flag when no new edge arrives.
    ack_clear_a: assert property (vec_ack[0] && !ded_evt |=> !s_ff.flags[0])
        else $error("vector entry did not clear flag");
    // A group 0 request always has its enables and flag behind it.
    group0_gate_a: assert property (vec_req[1] |-> $past(cpu_global_en) && s_ff.enable[4] && s_ff.flags[4])
        else $error("group 0 request without enables");
    // The dedicated request falls whenever the global enable was low.
    ded_gate_a: assert property (!cpu_global_en |=> !vec_req[0])
        else $error("dedicated request with global enable low");
    // The event interrupt matches the masked status.
    irq_match_a: assert property (irq == |(s_ff.evt_stat & s_ff.evt_mask))
        else $error("interrupt output disagrees with status");

endmodule // epiu_top

// >>> rtl/epiu_pkg.sv
// Shared definitions for the external pin interrupt unit: register offsets,
// field positions, writable-bit masks, reset values and the carrier structs.
// Assumes a single system clock and an eight-bit register port.
package epiu_pkg;

    // Register offsets on the register port.
    localparam logic [5:0] OFF_MASK0     = 6'h09;  // Pin-change mask, group 0.
    localparam logic [5:0] OFF_MASK1     = 6'h0C;  // Pin-change mask, group 1.
    localparam logic [5:0] OFF_MASK2     = 6'h1A;  // Pin-change mask, group 2.
    localparam logic [5:0] OFF_EVT_STAT  = 6'h30;  // Sticky event status, cleared by read.
    localparam logic [5:0] OFF_EVT_MASK  = 6'h31;  // Event interrupt mask.
    localparam logic [5:0] OFF_SENSE     = 6'h35;  // Sense control.
    localparam logic [5:0] OFF_FLAGS     = 6'h3A;  // Interrupt flags.
    localparam logic [5:0] OFF_ENABLE    = 6'h3B;  // Interrupt enable mask.

    // Bit positions shared by the enable, flag and event registers.
    localparam int BIT_DED = 0;  // Dedicated pin source.
    localparam int BIT_G0  = 4;  // Pin-change group 0.
    localparam int BIT_G1  = 5;  // Pin-change group 1.
    localparam int BIT_G2  = 6;  // Pin-change group 2.
    localparam int SENSE_LSB = 6;  // Low bit of the sense select field.

    // Writable-bit masks; all other bits read as zero.
    localparam logic [7:0] RW_MASK0 = 8'hFF;
    localparam logic [7:0] RW_MASK1 = 8'h0F;
    localparam logic [7:0] RW_MASK2 = 8'h3F;
    localparam logic [7:0] RW_SENSE = 8'hC0;
    localparam logic [7:0] RW_SRC   = 8'h71;  // Enable, flag and event layout.

    // Reset value of every register.
    localparam logic [7:0] RST_REG = 8'h00;

    // Vector request indices.
    localparam int VEC_DED = 0;
    localparam int VEC_G0  = 1;
    localparam int VEC_G1  = 2;
    localparam int VEC_G2  = 3;

    // Sense select encodings for the dedicated pin.
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } epiu_sense_e;

    // External pins watched by the unit.
    typedef struct packed {
        logic [17:0] change_input;       // Pin-change inputs 17 to 0.
        logic        dedicated_ext_irq;  // Dedicated interrupt pin.
    } epiu_pins_s;

    // One register port request.
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } epiu_bus_s;

    // Whole state of the unit.
    typedef struct packed {
        epiu_pins_s  sync1;      // First synchroniser stage.
        epiu_pins_s  sync2;      // Second synchroniser stage.
        epiu_pins_s  prev;       // Previous sample for edge detection.
        epiu_sense_e sense;      // Sense select field.
        logic [7:0]  enable;     // Interrupt enable mask.
        logic [7:0]  flags;      // Interrupt flags.
        logic [7:0]  mask0;      // Group 0 pin mask.
        logic [7:0]  mask1;      // Group 1 pin mask.
        logic [7:0]  mask2;      // Group 2 pin mask.
        logic [7:0]  evt_stat;   // Sticky event status.
        logic [7:0]  evt_mask;   // Event interrupt mask.
        logic [7:0]  rdata;      // Read data.
        logic [3:0]  vec_req;    // Vector requests.
        logic        irq;        // Event interrupt output.
        logic        wake;       // Wake request.
    } epiu_state_s;

endpackage

// >>> bench/epiu_partner.sv
// Far-side model: drives the external pins and plays the CPU core
// that enters vectors. Assumes the bench sets pin_cmd and ack controls.
`timescale 1ns/100ps
module epiu_partner (
    // Clock and reset.
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    // Bench controls.
    input  wire logic [18:0]     pin_cmd,
    input  wire logic            ack_en,
    input  wire logic [3:0]      ack_lat,
    // Unit side.
    input  wire logic [3:0]      vec_req,
    output epiu_pkg::epiu_pins_s pins,
    output logic [3:0]           vec_ack
);
    logic [3:0] wait_ff;  // Cycles the current request has waited.

    // Pins follow the command one edge later and hold until told otherwise.
    // The core acks the lowest pending vector after ack_lat cycles.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pins    <= 19'h00001;
            vec_ack <= 4'h0;
            wait_ff <= 4'h0;
        end else begin
            pins    <= pin_cmd;
            vec_ack <= 4'h0;
            if (ack_en && vec_req != 4'h0 && vec_ack == 4'h0) begin
                wait_ff <= wait_ff + 4'h1;
                if (wait_ff >= ack_lat) begin
                    vec_ack <= vec_req & (~vec_req + 4'h1);
                    wait_ff <= 4'h0;
                end
            end else begin
                // A gap after each entry lets the request drop first.
                wait_ff <= 4'h0;
            end
        end
    end
endmodule  // epiu_partner

// >>> bench/tb.sv
// Self-checking bench for the pin interrupt unit.
// Assumes the partner model drives pins and vector acks.
`timescale 1ns/100ps
module tb;
    logic                 clk_sys, nrst, cpu_global_en, ack_en, irq, wake_req;
    logic [18:0]          pin_cmd;     // Bit 0 dedicated pin, above it inputs.
    logic [3:0]           ack_lat, vec_req, vec_ack;
    logic [7:0]           rdata, rd_val;
    logic [7:0]           rnd;         // Random value written in the read-back test.
    epiu_pkg::epiu_pins_s pins;
    epiu_pkg::epiu_bus_s  bus;
    int                   failures, compares, seed, idx, g, exp_flags;
    // Registers checked for read-back and their writable bits.
    logic [5:0] offs [7] = '{epiu_pkg::OFF_MASK0, epiu_pkg::OFF_MASK1, epiu_pkg::OFF_MASK2,
        epiu_pkg::OFF_EVT_MASK, epiu_pkg::OFF_SENSE, epiu_pkg::OFF_ENABLE, 6'h3F};
    logic [7:0] rwm [7] = '{epiu_pkg::RW_MASK0, epiu_pkg::RW_MASK1, epiu_pkg::RW_MASK2,
        epiu_pkg::RW_SRC, epiu_pkg::RW_SENSE, epiu_pkg::RW_SRC, 8'h00};

    epiu_top uut (.clk_sys(clk_sys), .nrst(nrst), .pins(pins), .bus(bus), .rdata(rdata),
        .cpu_global_en(cpu_global_en), .vec_ack(vec_ack), .vec_req(vec_req), .irq(irq),
        .wake_req(wake_req));
    epiu_partner far (.clk_sys(clk_sys), .nrst(nrst), .pin_cmd(pin_cmd), .ack_en(ack_en),
        .ack_lat(ack_lat), .vec_req(vec_req), .pins(pins), .vec_ack(vec_ack));

    // Clock of 100 ns.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Compares and counts.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        // Let the outputs launched at this edge settle before anyone looks.
        #1;
    endtask

    // One-cycle read; data is taken in the cycle after the strobe.
    task automatic rd(input logic [5:0] a);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 rd_val = rdata;
    endtask

    // New pin levels and a settling wait.
    task automatic drive(input logic [18:0] v);
        @(posedge clk_sys);
        pin_cmd <= v;
        repeat (5) @(posedge clk_sys);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        report_and_stop();
    end

    initial begin
        nrst = 1'b0; cpu_global_en = 1'b0; ack_en = 1'b0; ack_lat = 4'h1;
        pin_cmd = 19'h00001; bus = '0; failures = 0; compares = 0;
        seed = 32'hA6CAF978;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        // Reset values, then random and all-ones read-back.
        foreach (offs[i]) begin
            rd(offs[i]); chk(rd_val, 8'h00, "reset value");
            rnd = 8'($random(seed));
            wr(offs[i], rnd); rd(offs[i]);
            chk(rd_val, rnd & rwm[i], "read back");
            wr(offs[i], 8'hFF); rd(offs[i]); chk(rd_val, rwm[i], "ones");
        end
        rd(epiu_pkg::OFF_FLAGS); chk(rd_val, 8'h00, "flags idle");
        $display("registers done");
        // Six random pins over all groups: flag, vector, then entry by the core.
        cpu_global_en <= 1'b1;
        repeat (6) begin
            idx = $unsigned($random(seed)) % 18;
            g = (idx < 8) ? 0 : (idx < 12) ? 1 : 2;
            drive(pin_cmd ^ (19'h00002 << idx));
            rd(epiu_pkg::OFF_FLAGS); chk(rd_val, 8'(8'h10 << g), "group flag");
            chk({4'h0, vec_req}, 8'(8'h02 << g), "group vector");
            ack_lat <= (ack_lat == 4'h1) ? 4'h5 : 4'h1;
            ack_en <= 1'b1;
            repeat (10) @(posedge clk_sys);
            ack_en <= 1'b0;
            chk({4'h0, vec_req}, 8'h00, "vector entered");
            rd(epiu_pkg::OFF_FLAGS); chk(rd_val, 8'h00, "flag entered");
        end
        $display("groups done");
        // Masked pins, no global enable, write-one clear and event interrupt.
        wr(epiu_pkg::OFF_EVT_MASK, 8'h00); rd(epiu_pkg::OFF_EVT_STAT);
        wr(epiu_pkg::OFF_MASK0, 8'h01); wr(epiu_pkg::OFF_MASK1, 8'h00); wr(epiu_pkg::OFF_MASK2, 8'h00);
        cpu_global_en <= 1'b0;
        drive(pin_cmd ^ 19'h7FFFC);
        rd(epiu_pkg::OFF_FLAGS); chk(rd_val, 8'h00, "masked pins");
        drive(pin_cmd ^ 19'h00002);
        chk({4'h0, vec_req}, 8'h00, "no global");
        chk({7'h0, irq}, 8'h00, "masked event");
        wr(epiu_pkg::OFF_FLAGS, 8'h00); rd(epiu_pkg::OFF_FLAGS); chk(rd_val, 8'h10, "write zero");
        wr(epiu_pkg::OFF_FLAGS, 8'h10); rd(epiu_pkg::OFF_FLAGS); chk(rd_val, 8'h00, "write one");
        wr(epiu_pkg::OFF_EVT_MASK, 8'h10);
        chk({7'h0, irq}, 8'h01, "event raised");
        rd(epiu_pkg::OFF_EVT_STAT); chk(rd_val, 8'h10, "event status");
        chk({7'h0, irq}, 8'h00, "event cleared");
        $display("masking done");
        // Every sense mode against a falling and a rising edge.
        cpu_global_en <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            for (int e = 0; e < 2; e++) begin
                wr(epiu_pkg::OFF_SENSE, 8'(m << 6));
                wr(epiu_pkg::OFF_FLAGS, 8'h01);
                drive({pin_cmd[18:1], e[0]});
                exp_flags = (m == 1 || m == 2 + e) ? 1 : 0;
                rd(epiu_pkg::OFF_FLAGS); chk(rd_val, 8'(exp_flags), "sense flag");
                chk({7'h0, vec_req[0]}, (m == 0) ? 8'(1 - e) : 8'(exp_flags), "sense vector");
                chk({7'h0, wake_req}, (m == 0 && e == 0) ? 8'h01 : 8'h00, "level wake");
            end
        end
        $display("sense done");
        report_and_stop();
    end
endmodule  // tb
